// >>> hw/fwmp_consts.svh
/*
  named constants of the flash writer-mode command port.
  assumes a 250 MHz core clock and a byte-wide writer data bus.
*/
`ifndef FWMP_CONSTS_SVH
`define FWMP_CONSTS_SVH
// command codes on the writer data bus
`define FWMP_CMD_READ 8'h00
`define FWMP_CMD_PROG 8'h40
`define FWMP_CMD_ERASE 8'h20
`define FWMP_CMD_STAT 8'h71
// page geometry and legal page base offsets
`define FWMP_PAGE_BYTES 8'h80
`define FWMP_PAGE_LAST 8'h7f
`define FWMP_PAGE_LO_A 8'h00
`define FWMP_PAGE_LO_B 8'h80
`define FWMP_ERASED_BYTE 8'hff
// status return code bit positions
`define FWMP_ST_ABN 7
`define FWMP_ST_CMD 6
`define FWMP_ST_PRG 5
`define FWMP_ST_ERS 4
`define FWMP_ST_CNT 1
`define FWMP_ST_ADR 0
`define FWMP_CODE_RST 8'h00
// polling pair {op end, end ok}
`define FWMP_POLL_BUSY 2'h0
`define FWMP_POLL_ABN 2'h2
`define FWMP_POLL_OK 2'h3
// timing
`define FWMP_CLK_MHZ 250
`define FWMP_OSC_SETTLE_MS 10
`define FWMP_SETUP_MS 10
`define FWMP_FIFO_DEPTH 8
`endif

// >>> hw/fwmp_pkg.sv
/*
  types of the flash writer-mode command port.
  assumes fwmp_consts.svh supplies the command, page, status and timing constants.
*/
package fwmp_pkg;
  // writer bus as sampled by the core clock
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [17:0] writer_address_bus;
    logic [7:0] writer_data_bus;
  } fwmp_bus_t;
  // result of one internal program or erase pass
  typedef struct packed {
    logic done;
    logic prog_err;
    logic erase_err;
    logic count_err;
  } fwmp_arr_res_t;
  typedef enum logic [3:0] {
    ST_SETTLE = 4'h0,
    ST_SETUP = 4'h1,
    ST_IDLE = 4'h3,
    ST_PROG_DATA = 4'h2,
    ST_PROG_BUSY = 4'h6,
    ST_ERASE2 = 4'h7,
    ST_ERASE_BUSY = 4'h5,
    ST_STAT2 = 4'h4
  } fwmp_state_t;
  typedef enum logic [1:0] {
    OUT_READ = 2'h0,
    OUT_POLL = 2'h1,
    OUT_STAT = 2'h3
  } fwmp_out_t;
endpackage : fwmp_pkg

// >>> hw/fwmp_port.sv
/*
  writer-mode command port with its page fifo.
  assumes writer pins already synchronous to core_clk and a flash array
  that drains page bytes, then reports one done pulse per operation.
*/
`timescale 1ns/100ps
`include "fwmp_consts.svh"

module fwmp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `FWMP_FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side, data held in a flop
  output logic out_valid_q,
  output logic [WIDTH-1:0] out_data_q,
  input wire logic out_ready,
  // levels
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = (cnt_q != '0) && (!out_valid_q || out_ready);
  // the output flop counts as storage only once loaded
  // depth compared at counter width; a narrower cast would wrap to zero
  assign full = (cnt_q == (AW+1)'(DEPTH));
  assign in_ready = !full;
  assign empty = (cnt_q == '0) && !out_valid_q;

  always_ff @(posedge core_clk) begin
    if (push) mem[wr_q] <= in_data;
  end

  // pointers wrap at the power-of-two depth
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      if (pop) begin
        out_valid_q <= 1'b1;
        out_data_q <= mem[rd_q];
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
    end
  end
endmodule : fwmp_fifo

module fwmp_port #(
  parameter int OSC_CYC = `FWMP_OSC_SETTLE_MS * 1000 * `FWMP_CLK_MHZ,
  parameter int SETUP_CYC = `FWMP_SETUP_MS * 1000 * `FWMP_CLK_MHZ
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // writer bus from the programmer
  input wire fwmp_pkg::fwmp_bus_t bus,
  output logic [7:0] data_out_q,
  output logic data_oe_q,
  // array read path
  output logic [17:0] arr_rd_addr_q,
  input wire logic [7:0] arr_rd_data,
  // array program and erase control
  output logic arr_prog_start_q,
  output logic [17:0] arr_page_addr_q,
  output logic arr_erase_start_q,
  input wire fwmp_pkg::fwmp_arr_res_t arr_res,
  // page bytes toward the array
  output logic arr_wr_valid_q,
  output logic [7:0] arr_wr_data_q,
  input wire logic arr_wr_ready,
  // port state seen by the core
  output logic busy_q
);
  fwmp_pkg::fwmp_state_t state_q, state_d;
  fwmp_pkg::fwmp_out_t out_q, out_d;
  logic [31:0] tmr_q;
  logic we_prev_q, pend_q, addr_bad_q;
  logic [7:0] pend_data_q, byte_cnt_q, code_q;
  logic [1:0] poll_q;
  logic fifo_ready;

  // bus decode; a write is taken once at the falling we edge
  wire sel_rd = !bus.ce_n && !bus.oe_n && bus.we_n;
  wire cmd_wr = !bus.ce_n && !bus.we_n && we_prev_q;
  wire [7:0] din = bus.writer_data_bus;
  wire [7:0] lo = bus.writer_address_bus[7:0];
  wire lo_ok = (lo == `FWMP_PAGE_LO_A) || (lo == `FWMP_PAGE_LO_B);
  wire busy = (state_q == fwmp_pkg::ST_PROG_BUSY)
           || (state_q == fwmp_pkg::ST_ERASE_BUSY);
  wire cmd_ok = (state_q == fwmp_pkg::ST_IDLE) && cmd_wr;
  wire page_wr = (state_q == fwmp_pkg::ST_PROG_DATA) && cmd_wr;
  wire push = pend_q && fifo_ready;
  wire page_full = (byte_cnt_q == `FWMP_PAGE_BYTES);
  wire op_end = busy && arr_res.done;
  wire bad_cmd = cmd_ok && (din != `FWMP_CMD_READ)
              && (din != `FWMP_CMD_PROG) && (din != `FWMP_CMD_ERASE)
              && (din != `FWMP_CMD_STAT);
  wire bad_2nd = cmd_wr && (((state_q == fwmp_pkg::ST_ERASE2)
              && (din != `FWMP_CMD_ERASE)) || ((state_q == fwmp_pkg::ST_STAT2)
              && (din != `FWMP_CMD_STAT)));
  wire tmr_done = (tmr_q == 32'h0);
  // a stale bad page address must not fail a later erase
  wire err_any = arr_res.prog_err || arr_res.erase_err
              || arr_res.count_err
              || (addr_bad_q && state_q == fwmp_pkg::ST_PROG_BUSY);
  // code a new operation may clear; a status read never does
  wire code_clr = cmd_ok && ((din == `FWMP_CMD_READ)
               || (din == `FWMP_CMD_PROG) || (din == `FWMP_CMD_ERASE));

  // next state and output mode
  always_comb begin
    state_d = state_q;
    out_d = out_q;
    case (state_q)
      fwmp_pkg::ST_SETTLE: if (tmr_done) state_d = fwmp_pkg::ST_SETUP;
      fwmp_pkg::ST_SETUP: if (tmr_done) begin
        state_d = fwmp_pkg::ST_IDLE;
        out_d = fwmp_pkg::OUT_READ;
      end
      fwmp_pkg::ST_IDLE: if (cmd_ok) begin
        case (din)
          `FWMP_CMD_READ: out_d = fwmp_pkg::OUT_READ;
          `FWMP_CMD_PROG: state_d = fwmp_pkg::ST_PROG_DATA;
          `FWMP_CMD_ERASE: state_d = fwmp_pkg::ST_ERASE2;
          `FWMP_CMD_STAT: state_d = fwmp_pkg::ST_STAT2;
          default: state_d = fwmp_pkg::ST_IDLE;
        endcase
      end
      fwmp_pkg::ST_PROG_DATA: if (page_full) begin
        state_d = fwmp_pkg::ST_PROG_BUSY;
        out_d = fwmp_pkg::OUT_POLL;
      end
      fwmp_pkg::ST_ERASE2: if (cmd_wr) begin
        state_d = bad_2nd ? fwmp_pkg::ST_IDLE : fwmp_pkg::ST_ERASE_BUSY;
        if (!bad_2nd) out_d = fwmp_pkg::OUT_POLL;
      end
      fwmp_pkg::ST_STAT2: if (cmd_wr) begin
        state_d = fwmp_pkg::ST_IDLE;
        if (!bad_2nd) out_d = fwmp_pkg::OUT_STAT;
      end
      fwmp_pkg::ST_PROG_BUSY,
      fwmp_pkg::ST_ERASE_BUSY: if (op_end) state_d = fwmp_pkg::ST_IDLE;
      default: state_d = fwmp_pkg::ST_SETTLE;
    endcase
  end

  // sequencer and power-up timers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= fwmp_pkg::ST_SETTLE;
      out_q <= fwmp_pkg::OUT_READ;
      tmr_q <= 32'(OSC_CYC);
      we_prev_q <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      out_q <= out_d;
      we_prev_q <= bus.we_n;
      busy_q <= busy;
      if (state_q == fwmp_pkg::ST_SETTLE && tmr_done) tmr_q <= 32'(SETUP_CYC);
      else if (!tmr_done) tmr_q <= tmr_q - 32'h1;
    end
  end

  // page capture; a stalled fifo holds the byte in the pending flop
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pend_q <= 1'b0;
      pend_data_q <= 8'h00;
      byte_cnt_q <= 8'h00;
      addr_bad_q <= 1'b0;
      arr_page_addr_q <= 18'h00000;
      arr_prog_start_q <= 1'b0;
      arr_erase_start_q <= 1'b0;
    end else begin
      pend_q <= page_wr || (pend_q && !push);
      if (page_wr) pend_data_q <= din;
      if (cmd_ok) byte_cnt_q <= 8'h00;
      else if (push) byte_cnt_q <= byte_cnt_q + 8'h01;
      // address only taken with the first page byte
      if (page_wr && byte_cnt_q == 8'h00 && !pend_q) begin
        arr_page_addr_q <= bus.writer_address_bus;
        addr_bad_q <= !lo_ok;
      end
      arr_prog_start_q <= (state_q == fwmp_pkg::ST_PROG_DATA) && page_full;
      arr_erase_start_q <= (state_q == fwmp_pkg::ST_ERASE2)
                        && cmd_wr && !bad_2nd;
    end
  end

  // return code and polling pair
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      code_q <= `FWMP_CODE_RST;
      poll_q <= `FWMP_POLL_BUSY;
    end else begin
      if (op_end) begin
        code_q[`FWMP_ST_ABN] <= err_any;
        code_q[`FWMP_ST_PRG] <= arr_res.prog_err;
        code_q[`FWMP_ST_ERS] <= arr_res.erase_err;
        code_q[`FWMP_ST_CNT] <= arr_res.count_err;
        code_q[`FWMP_ST_ADR] <= addr_bad_q && (state_q == fwmp_pkg::ST_PROG_BUSY);
        poll_q <= err_any ? `FWMP_POLL_ABN : `FWMP_POLL_OK;
      end else if (bad_cmd || bad_2nd) begin
        code_q[`FWMP_ST_ABN] <= 1'b1;
        code_q[`FWMP_ST_CMD] <= 1'b1;
      end else if (code_clr) begin
        code_q <= `FWMP_CODE_RST;
      end
      if (cmd_ok && (din == `FWMP_CMD_PROG || din == `FWMP_CMD_ERASE))
        poll_q <= `FWMP_POLL_BUSY;
    end
  end

  // read path; data bus released unless a read is selected after settle and setup
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_oe_q <= 1'b0;
      data_out_q <= 8'h00;
      arr_rd_addr_q <= 18'h00000;
    end else begin
      data_oe_q <= sel_rd && !(state_q == fwmp_pkg::ST_SETTLE
                || state_q == fwmp_pkg::ST_SETUP);
      arr_rd_addr_q <= bus.writer_address_bus;
      case (out_q)
        fwmp_pkg::OUT_POLL: data_out_q <= {poll_q, 6'h00};
        fwmp_pkg::OUT_STAT: data_out_q <= code_q;
        default: data_out_q <= arr_rd_data;
      endcase
    end
  end

  fwmp_fifo #(.WIDTH(8), .DEPTH(`FWMP_FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .reset(reset),
    .in_valid(pend_q),
    .in_data(pend_data_q),
    .in_ready(fifo_ready),
    .out_valid_q(arr_wr_valid_q),
    .out_data_q(arr_wr_data_q),
    .out_ready(arr_wr_ready),
    .full(),
    .empty()
  );

  // checks
  a_settle_ignore: assert property (@(posedge core_clk) disable iff (reset)
    (state_q == fwmp_pkg::ST_SETTLE && !tmr_done) |=>
      state_q == fwmp_pkg::ST_SETTLE) else $error("left settle early");
  a_setup_exit: assert property (@(posedge core_clk) disable iff (reset)
    (state_q == fwmp_pkg::ST_SETUP && tmr_done) |=>
      state_q == fwmp_pkg::ST_IDLE && out_q == fwmp_pkg::OUT_READ)
    else $error("no read mode after setup");
  a_page_start: assert property (@(posedge core_clk) disable iff (reset)
    arr_prog_start_q |-> $past(byte_cnt_q) == `FWMP_PAGE_BYTES
      && state_q == fwmp_pkg::ST_PROG_BUSY)
    else $error("program began before full page");
  a_bad_addr: assert property (@(posedge core_clk) disable iff (reset)
    (state_q == fwmp_pkg::ST_PROG_BUSY && op_end && addr_bad_q) |=>
      code_q[0] && code_q[7] && poll_q == 2'h2)
    else $error("bad page address not flagged");
  a_poll_busy: assert property (@(posedge core_clk) disable iff (reset)
    (busy && out_q == fwmp_pkg::OUT_POLL && sel_rd) |=> data_out_q == 8'h00)
    else $error("busy poll not zero");
  a_poll_hold: assert property (@(posedge core_clk) disable iff (reset)
    (!busy && !cmd_wr) |=> $stable(poll_q))
    else $error("poll flags moved without command");
  a_code_hold: assert property (@(posedge core_clk) disable iff (reset)
    (!cmd_wr && !op_end) |=> $stable(code_q))
    else $error("return code moved");
  a_erase_whole: assert property (@(posedge core_clk) disable iff (reset)
    arr_erase_start_q |-> $past(state_q) == fwmp_pkg::ST_ERASE2)
    else $error("erase without second cycle");
  a_stat_out: assert property (@(posedge core_clk) disable iff (reset)
    (out_q == fwmp_pkg::OUT_STAT && sel_rd && !cmd_wr) |=>
      data_oe_q && data_out_q == $past(code_q))
    else $error("status code not driven");
  c_prog_done: cover property (@(posedge core_clk) disable iff (reset)
    state_q == fwmp_pkg::ST_PROG_BUSY && op_end);
  c_erase_done: cover property (@(posedge core_clk) disable iff (reset)
    state_q == fwmp_pkg::ST_ERASE_BUSY && op_end);
  c_stat_read: cover property (@(posedge core_clk) disable iff (reset)
    out_q == fwmp_pkg::OUT_STAT && sel_rd);
endmodule : fwmp_port

// >>> test/fwmp_array_model.sv
/*
  flash array stand-in: read pattern, page byte sink, done pulses.
  assumes the port's array-side handshake on the one core clock.
*/
`timescale 1ns/100ps

module fwmp_array_model #(
  parameter int BUSY_CYC = 40
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // array side of the port
  input wire logic [17:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic prog_start,
  input wire logic erase_start,
  output fwmp_pkg::fwmp_arr_res_t res,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  // test controls and counts
  input wire logic stall,
  input wire logic [2:0] err_sel,
  output int n_bytes,
  output logic [7:0] last_byte
);
  int cnt;
  logic run;
  // data follows the address, so a stale read shows up
  assign rd_data = rd_addr[7:0] ^ 8'h5a;
  // a stalled array lets the page fifo fill
  assign wr_ready = !stall;
  // one done per start; the busy count pauses while stalled
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      run <= 1'b0;
      cnt <= 0;
      res <= '0;
    end else begin
      res <= '0;
      if (prog_start || erase_start) begin
        run <= 1'b1;
        cnt <= 0;
      end else if (run && !stall) begin
        cnt <= cnt + 1;
        if (cnt == BUSY_CYC) begin
          run <= 1'b0;
          res <= {1'b1, err_sel};
        end
      end
    end
  end
  // page bytes taken on valid and ready
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      n_bytes <= 0;
      last_byte <= 8'h00;
    end else if (wr_valid && wr_ready) begin
      n_bytes <= n_bytes + 1;
      last_byte <= wr_data;
    end
  end
endmodule : fwmp_array_model

// >>> test/tb_fwmp_port.sv
/*
  bench for the writer-mode port: programmer bus tasks and sequences.
  assumes short settle and setup counts and the array stand-in.
*/
`timescale 1ns/100ps
`include "fwmp_consts.svh"

module tb_fwmp_port;
  logic core_clk;
  logic reset;
  fwmp_pkg::fwmp_bus_t bus;
  logic [7:0] data_out_q;
  logic data_oe_q;
  logic [17:0] arr_rd_addr_q;
  logic [7:0] arr_rd_data;
  logic arr_prog_start_q;
  logic [17:0] arr_page_addr_q;
  logic arr_erase_start_q;
  fwmp_pkg::fwmp_arr_res_t arr_res;
  logic arr_wr_valid_q;
  logic [7:0] arr_wr_data_q;
  logic arr_wr_ready;
  logic busy_q;
  logic stall;
  logic [2:0] err_sel;
  int n_bytes;
  logic [7:0] last_byte;
  int mismatches;
  int n_compared;
  int n_prog;
  int n_erase;
  logic [7:0] v;
  logic o;

  fwmp_port #(.OSC_CYC(20), .SETUP_CYC(20)) u_fwmp_port (
    .core_clk(core_clk), .reset(reset), .bus(bus),
    .data_out_q(data_out_q), .data_oe_q(data_oe_q),
    .arr_rd_addr_q(arr_rd_addr_q), .arr_rd_data(arr_rd_data),
    .arr_prog_start_q(arr_prog_start_q),
    .arr_page_addr_q(arr_page_addr_q),
    .arr_erase_start_q(arr_erase_start_q), .arr_res(arr_res),
    .arr_wr_valid_q(arr_wr_valid_q), .arr_wr_data_q(arr_wr_data_q),
    .arr_wr_ready(arr_wr_ready), .busy_q(busy_q));

  fwmp_array_model u_fwmp_array_model (
    .core_clk(core_clk), .reset(reset), .rd_addr(arr_rd_addr_q),
    .rd_data(arr_rd_data), .prog_start(arr_prog_start_q),
    .erase_start(arr_erase_start_q), .res(arr_res),
    .wr_valid(arr_wr_valid_q), .wr_data(arr_wr_data_q),
    .wr_ready(arr_wr_ready), .stall(stall), .err_sel(err_sel),
    .n_bytes(n_bytes), .last_byte(last_byte));

  // 250 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // start pulses counted as they pass
  always @(posedge core_clk) begin
    if (arr_prog_start_q === 1'b1) n_prog <= n_prog + 1;
    if (arr_erase_start_q === 1'b1) n_erase <= n_erase + 1;
  end

  task automatic check(string name, logic [17:0] seen, logic [17:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // write cycle: strobe low over one sampling edge; data inverted after
  task automatic wr(logic [17:0] a, logic [7:0] d);
    @(posedge core_clk);
    bus.ce_n <= 1'b0;
    bus.we_n <= 1'b0;
    bus.writer_address_bus <= a;
    bus.writer_data_bus <= d;
    @(posedge core_clk);
    bus.ce_n <= 1'b1;
    bus.we_n <= 1'b1;
    bus.writer_data_bus <= ~d;
  endtask : wr

  // read cycle: select held until the answer has settled
  task automatic rd(logic [17:0] a);
    @(posedge core_clk);
    bus.ce_n <= 1'b0;
    bus.oe_n <= 1'b0;
    bus.writer_address_bus <= a;
    repeat (3) @(posedge core_clk);
    #1;
    v = data_out_q;
    o = data_oe_q;
    @(posedge core_clk);
    bus.ce_n <= 1'b1;
    bus.oe_n <= 1'b1;
  endtask : rd

  task automatic stat();
    wr(18'h0, `FWMP_CMD_STAT);
    wr(18'h0, `FWMP_CMD_STAT);
    rd(18'h0);
  endtask : stat

  // bounded wait, no command write while busy
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_q !== 1'b0 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    check("busy_q end", busy_q, 18'h0);
  endtask : wait_idle

  // one program page or erase, then poll and status code
  task automatic op(bit er, logic [17:0] a, logic [2:0] e,
                    logic [7:0] ep, logic [7:0] es);
    int b;
    int p;
    b = n_bytes;
    p = er ? n_erase : n_prog;
    err_sel <= e;
    if (er) begin
      wr(18'h0, `FWMP_CMD_ERASE);
      wr(18'h0, `FWMP_CMD_ERASE);
    end else begin
      wr(18'h0, `FWMP_CMD_PROG);
      for (int i = 0; i < 128; i++) begin
        if (i == 8) stall <= 1'b0;
        if (i == 127) check("early start", 18'(n_prog - p), 18'h0);
        // address with the first byte only, unused bytes padded
        wr(i == 0 ? a : 18'h0, i < 4 ? 8'(i) : `FWMP_ERASED_BYTE);
      end
    end
    repeat (4) @(posedge core_clk);
    check("busy_q run", busy_q, 18'h1);
    check("starts", 18'((er ? n_erase : n_prog) - p), 18'h1);
    rd(a);
    check("busy poll", v, 18'h0);
    wait_idle();
    rd(a);
    check("poll", v, ep);
    if (!er) begin
      check("page bytes", 18'(n_bytes - b), 18'h80);
      check("last byte", last_byte, `FWMP_ERASED_BYTE);
      check("page addr", arr_page_addr_q, a);
    end
    repeat (10) @(posedge core_clk);
    rd(a);
    check("poll held", v, ep);
    stat();
    check("code", v, es);
  endtask : op

  // a refused sequence, then the status code
  task automatic bad(logic [7:0] x, logic [7:0] y, bit two);
    wr(18'h0, `FWMP_CMD_READ);
    wr(18'h0, x);
    if (two) wr(18'h0, y);
    stat();
    check("cmd error", v, 8'hc0);
  endtask : bad

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // watchdog well beyond the few thousand cycles the run needs
  initial begin
    repeat (30000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    bus = '{1'b1, 1'b1, 1'b1, 18'h0, 8'h00};
    reset = 1'b1;
    stall = 1'b0;
    err_sel = 3'h0;
    mismatches = 0;
    n_compared = 0;
    n_prog = 0;
    n_erase = 0;
    repeat (2) @(posedge core_clk);
    #1;
    check("oe reset", data_oe_q, 18'h0);
    check("busy reset", busy_q, 18'h0);
    @(posedge core_clk);
    reset <= 1'b0;
    // reads and commands during settling are ignored
    rd(18'h00123);
    check("oe settle", o, 18'h0);
    wr(18'h0, `FWMP_CMD_ERASE);
    wr(18'h0, `FWMP_CMD_ERASE);
    repeat (40) @(posedge core_clk);
    check("erase early", 18'(n_erase), 18'h0);
    rd(18'h00123);
    check("oe read", o, 18'h1);
    check("read data", v, 8'h23 ^ 8'h5a);
    repeat (2) @(posedge core_clk);
    #1;
    check("oe released", data_oe_q, 18'h0);
    // unknown history: erase first, once failing, once clean
    op(1'b1, 18'h0, 3'h2, {`FWMP_POLL_ABN, 6'h00}, 8'h90);
    op(1'b1, 18'h0, 3'h0, {`FWMP_POLL_OK, 6'h00}, 8'h00);
    stall <= 1'b1;
    op(1'b0, 18'h00100, 3'h0, {`FWMP_POLL_OK, 6'h00}, 8'h00);
    op(1'b0, 18'h001c0, 3'h0, {`FWMP_POLL_ABN, 6'h00}, 8'h81);
    stat();
    check("code kept", v, 8'h81);
    wr(18'h0, `FWMP_CMD_READ);
    rd(18'h001a5);
    check("read mode", v, 8'ha5 ^ 8'h5a);
    stat();
    check("code cleared", v, 8'h00);
    op(1'b0, 18'h00200, 3'h4, {`FWMP_POLL_ABN, 6'h00}, 8'ha0);
    op(1'b0, 18'h00280, 3'h1, {`FWMP_POLL_ABN, 6'h00}, 8'h82);
    bad(8'h55, 8'h00, 1'b0);
    bad(`FWMP_CMD_ERASE, 8'h21, 1'b1);
    bad(`FWMP_CMD_STAT, 8'h70, 1'b1);
    end_of_test();
  end
endmodule : tb_fwmp_port
